// File: csrd_pkg.sv
// constants and carriers shared by the store and return decoder
package csrd_pkg;
  // opcodes
  localparam logic [7:0] OP_PREFIX   = 8'h9E;
  localparam logic [7:0] OP_SP_RESET = 8'h9C;
  localparam logic [7:0] OP_IRET     = 8'h80;
  localparam logic [7:0] OP_SRET     = 8'h81;
  localparam logic [7:0] OP_SEC      = 8'h99;
  localparam logic [7:0] OP_SEI      = 8'h9B;
  localparam logic [7:0] OP_STOP     = 8'h8E;
  localparam logic [7:0] OP_INDEX_PAIR_STORE_OP_DIR = 8'h35;
  localparam logic [7:0] OP_INDEX_PAIR_STORE_OP_EXT = 8'h96;
  localparam logic [7:0] OP_INDEX_PAIR_STORE_OP_SP1 = 8'hFF;
  // opcode low nibbles of the grouped families
  localparam logic [3:0] LO_SBC = 4'h2;
  localparam logic [3:0] LO_STA = 4'h7;
  localparam logic [3:0] LO_STX = 4'hF;
  // addressing mode high nibbles
  localparam logic [3:0] HI_IMM = 4'hA;
  localparam logic [3:0] HI_DIR = 4'hB;
  localparam logic [3:0] HI_EXT = 4'hC;
  localparam logic [3:0] HI_IX2 = 4'hD;
  localparam logic [3:0] HI_IX1 = 4'hE;
  localparam logic [3:0] HI_IX  = 4'hF;
  // condition code bit positions
  localparam int CC_C = 0;
  localparam int CC_Z = 1;
  localparam int CC_N = 2;
  localparam int CC_I = 3;
  localparam int CC_V = 7;
  // reset and fixed values
  localparam logic [7:0]  RST_INDEX_HIGH = 8'h00;
  localparam logic [7:0]  SP_LOW_FILL    = 8'hFF;
  localparam logic [7:0]  CC_FIXED_ONES  = 8'h60;
  localparam logic [15:0] RST_PC         = 16'h0000;
  localparam logic [15:0] RST_SP         = 16'h00FF;
  localparam logic [7:0]  RST_CC         = 8'h68;

  // one memory bus request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } csrd_bus_type;
endpackage : csrd_pkg

// File: csrd_core.sv
// decoder and executor for the store, return and flag instruction subset
`timescale 1ns/1ns
`default_nettype none
module csrd_core
  import csrd_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [7:0]   i_rdata,
  output logic              o_rd,
  output logic              o_wr,
  output logic [15:0]       o_addr,
  output logic [7:0]        o_wdata,
  output logic              o_halted,
  output logic              o_illegal
);
  // sequencer states
  //   S_FETCH  : issue the opcode read at pc
  //   S_DECODE : take the opcode, run the one-cycle inherent forms at once
  //   S_OPHI   : refuse opcodes outside the subset, size the operand field
  //   S_OPLO   : read operand bytes, then the data byte for subtract forms
  //   S_STORE2 : wait out the read latency of one operand byte
  //   S_EXEC   : finish subtract, or issue the store write
  //   S_PULL   : stack pulls of both return forms
  //   S_HALT   : second byte of the pair store, or the stopped state
  typedef enum {
    S_FETCH, S_DECODE, S_OPHI, S_OPLO, S_EXEC, S_STORE2, S_PULL, S_HALT
  } csrd_state_type;

  csrd_state_type state_q;
  // accumulator and index low keep their value over reset, so they
  // start unknown after power-up; a program must load them before use
  // core registers live only here, no address decodes them
  logic [7:0]  acc_q;
  logic [7:0]  idx_hi_q;
  logic [7:0]  idx_lo_q;
  logic [15:0] sp_q;
  logic [15:0] pc_q;
  logic [7:0]  cc_q;
  logic [7:0]  op_q;
  logic        pre_q;
  logic [15:0] opnd_q;
  logic [2:0]  pull_q;
  logic [2:0]  pull_n_q;
  csrd_bus_type bus_q;
  logic        halted_q;
  logic        illegal_q;

  wire logic [3:0] hi_nib = op_q[7:4];
  wire logic [3:0] lo_nib = op_q[3:0];
  wire logic [15:0] hx    = {idx_hi_q, idx_lo_q};

  // operand byte count for the grouped families
  // immediate data is the data byte itself, read later at pc, so it
  // carries no address bytes; plain indexed has none either
  function automatic logic [1:0] opnd_bytes(input logic [3:0] hn, input logic p);
    if (p) opnd_bytes = (hn == HI_IX2) ? 2'd2 : 2'd1;
    else if (hn == HI_EXT || hn == HI_IX2) opnd_bytes = 2'd2;
    else if (hn == HI_IX || hn == HI_IMM) opnd_bytes = 2'd0;
    else opnd_bytes = 2'd1;
  endfunction : opnd_bytes

  // effective address from mode; sp forms replace the index pair
  // offsets wrap at 16 bits, as a pointer past the top rolls to zero
  function automatic logic [15:0] eff_addr(input logic [3:0] hn, input logic p,
                                           input logic [15:0] o, input logic [15:0] x,
                                           input logic [15:0] s);
    logic [15:0] base;
    base = p ? s : x;
    case (hn)
      HI_DIR:  eff_addr = {8'h00, o[7:0]};
      HI_EXT:  eff_addr = o;
      HI_IX2:  eff_addr = 16'(base + o);
      HI_IX1:  eff_addr = 16'(base + {8'h00, o[7:0]});
      HI_IX:   eff_addr = x;
      default: eff_addr = o;
    endcase
  endfunction : eff_addr

  // the pair store does not follow the nibble grouping, so its opcodes
  // are mapped onto the matching mode nibble before the address is
  // formed; every other opcode uses its own high nibble
  wire logic [3:0]  ea_nib = (op_q == OP_INDEX_PAIR_STORE_OP_DIR) ? HI_DIR :
                             (op_q == OP_INDEX_PAIR_STORE_OP_EXT) ? HI_EXT :
                             (pre_q && op_q == OP_INDEX_PAIR_STORE_OP_SP1) ? HI_IX1 : hi_nib;
  wire logic [15:0] ea     = eff_addr(ea_nib, pre_q, opnd_q, hx, sp_q);
  wire logic        is_index_pair_store_op = (!pre_q && (op_q == OP_INDEX_PAIR_STORE_OP_DIR || op_q == OP_INDEX_PAIR_STORE_OP_EXT)) ||
                              (pre_q && op_q == OP_INDEX_PAIR_STORE_OP_SP1);
  // family decode from the low nibble; the low store gives way to the
  // pair store where both share an encoding after the prefix
  // anything that matches no family is refused in S_OPHI
  wire logic        is_sbc  = lo_nib == LO_SBC && hi_nib >= HI_IMM;
  wire logic        is_sta  = lo_nib == LO_STA && hi_nib >= HI_DIR;
  wire logic        is_stx  = lo_nib == LO_STX && hi_nib >= HI_DIR && !is_index_pair_store_op;
  wire logic        grp_ok  = is_index_pair_store_op || is_sbc || is_sta || is_stx;

  // subtract with borrow datapath
  // carry out of the 9-bit difference is the borrow flag
  wire logic [8:0]  diff = 9'({1'b0, acc_q} - {1'b0, i_rdata} - {8'h00, cc_q[CC_C]});
  wire logic        sbc_v = (acc_q[7] ^ i_rdata[7]) & (acc_q[7] ^ diff[7]);

  // bus request registered so outputs come straight from flops
  // cleared in reset as well, so the pins are quiet one edge after
  // reset is seen instead of showing power-up unknowns
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rd      <= 1'b0;
      o_wr      <= 1'b0;
      o_addr    <= '0;
      o_wdata   <= '0;
      o_halted  <= 1'b0;
      o_illegal <= 1'b0;
    end else begin
      o_rd      <= bus_q.rd;
      o_wr      <= bus_q.wr;
      o_addr    <= bus_q.addr;
      o_wdata   <= bus_q.wdata;
      o_halted  <= halted_q;
      o_illegal <= illegal_q;
    end
  end

  // bus timing seen from the sequencer: a request set in bus_q reaches
  // the pins one edge later, and the memory answers while o_rd stands,
  // so read data is taken at the edge where o_rd is seen high
  // strobes default low every cycle, which keeps each request a single
  // cycle pulse without a separate clear
  // cycle counts are longer than a single-bus core would need; only the
  // order of bus cycles and their effects are kept
  // main sequencer; acc and index low have no reset branch on purpose
  always_ff @(posedge i_clk) begin
    bus_q.rd <= 1'b0;
    bus_q.wr <= 1'b0;
    illegal_q <= 1'b0;
    if (i_srst) begin
      state_q  <= S_FETCH;
      idx_hi_q <= RST_INDEX_HIGH;
      sp_q     <= RST_SP;
      pc_q     <= RST_PC;
      cc_q     <= RST_CC;
      pre_q    <= 1'b0;
      halted_q <= 1'b0;
      bus_q    <= '0;
      op_q     <= '0;
      opnd_q   <= '0;
      pull_q   <= '0;
      pull_n_q <= '0;
    end else begin
      case (state_q)
        // opcode read; pc moves on at once so operand reads follow it
        // without a separate increment step
        S_FETCH: begin
          bus_q.rd   <= 1'b1;
          bus_q.addr <= pc_q;
          pc_q       <= 16'(pc_q + 16'h0001);
          state_q    <= S_DECODE;
        end
        S_DECODE: begin
          // read data answers two cycles after the request flop
          if (!o_rd) begin
            state_q <= S_DECODE;
          // a prefix costs one more fetch and is remembered until the
          // instruction it qualifies is done
          end else if (!pre_q && i_rdata == OP_PREFIX) begin
            pre_q   <= 1'b1;
            state_q <= S_FETCH;
          end else begin
            op_q    <= i_rdata;
            opnd_q  <= '0;
            state_q <= S_EXEC;
            if (!pre_q) begin
              case (i_rdata)
                OP_SP_RESET: begin
                  sp_q[7:0] <= SP_LOW_FILL;
                  state_q   <= S_FETCH;
                end
                OP_SEC: begin
                  cc_q[CC_C] <= 1'b1;
                  state_q    <= S_FETCH;
                end
                OP_SEI: begin
                  cc_q[CC_I] <= 1'b1;
                  state_q    <= S_FETCH;
                end
                OP_STOP: begin
                  cc_q[CC_I] <= 1'b0;
                  halted_q   <= 1'b1;
                  state_q    <= S_HALT;
                end
                OP_IRET: begin
                  pull_n_q <= 3'd5;
                  pull_q   <= '0;
                  sp_q     <= 16'(sp_q + 16'h0001);
                  state_q  <= S_PULL;
                end
                OP_SRET: begin
                  pull_n_q <= 3'd2;
                  pull_q   <= 3'd3;
                  sp_q     <= 16'(sp_q + 16'h0001);
                  state_q  <= S_PULL;
                end
                default: state_q <= S_OPHI;
              endcase
            end else begin
              state_q <= S_OPHI;
            end
          end
        end
        // refused opcodes make no bus cycle; pc already points past them,
        // so the next fetch simply skips the byte
        S_OPHI: begin
          if (!grp_ok) begin
            illegal_q <= 1'b1;
            pre_q     <= 1'b0;
            state_q   <= S_FETCH;
          end else begin
            pull_q <= 3'(opnd_bytes(ea_nib, pre_q));
            state_q <= S_OPLO;
          end
        end
        S_OPLO: begin
          // gather operand bytes, high first, then settle the address
          if (pull_q == 3'd0) begin
            if (is_sbc && hi_nib == HI_IMM && !pre_q) begin
              bus_q.rd   <= 1'b1;
              bus_q.addr <= pc_q;
              pc_q       <= 16'(pc_q + 16'h0001);
            end else if (is_sbc) begin
              bus_q.rd   <= 1'b1;
              bus_q.addr <= ea;
            end
            pull_q  <= 3'd0;
            state_q <= S_EXEC;
          end else begin
            bus_q.rd   <= 1'b1;
            bus_q.addr <= pc_q;
            pc_q       <= 16'(pc_q + 16'h0001);
            pull_q     <= 3'(pull_q - 3'd1);
            state_q    <= S_STORE2;
          end
        end
        S_STORE2: begin
          // wait out the read latency, then shift in one operand byte
          if (o_rd) begin
            opnd_q  <= {opnd_q[7:0], i_rdata};
            state_q <= S_OPLO;
          end
        end
        // subtract waits for its data byte; stores write at once
        // the pair store keeps the prefix flag alive for its second byte
        // and parks the next address in the operand register
        S_EXEC: begin
          pre_q   <= 1'b0;
          state_q <= S_FETCH;
          if (is_sbc) begin
            if (!o_rd) begin
              state_q <= S_EXEC;
              pre_q   <= pre_q;
            end else begin
              acc_q      <= diff[7:0];
              cc_q[CC_V] <= sbc_v;
              cc_q[CC_N] <= diff[7];
              cc_q[CC_Z] <= diff[7:0] == 8'h00;
              cc_q[CC_C] <= diff[8];
            end
          end else if (is_index_pair_store_op) begin
            bus_q.wr    <= 1'b1;
            bus_q.addr  <= ea;
            bus_q.wdata <= idx_hi_q;
            opnd_q      <= 16'(ea + 16'h0001);
            cc_q[CC_V]  <= 1'b0;
            cc_q[CC_N]  <= idx_hi_q[7];
            cc_q[CC_Z]  <= hx == 16'h0000;
            state_q     <= S_HALT;
            pre_q       <= pre_q;
          end else begin
            bus_q.wr    <= 1'b1;
            bus_q.addr  <= ea;
            bus_q.wdata <= is_sta ? acc_q : idx_lo_q;
            cc_q[CC_V]  <= 1'b0;
            cc_q[CC_N]  <= is_sta ? acc_q[7] : idx_lo_q[7];
            cc_q[CC_Z]  <= (is_sta ? acc_q : idx_lo_q) == 8'h00;
          end
        end
        // interrupt return starts at slot 0 (flags), subroutine return at
        // slot 3 (pc high), so both share one pull sequence
        S_PULL: begin
          // each pull reads at sp, then bumps sp before the next one
          if (pull_n_q == 3'd0) begin
            state_q <= S_FETCH;
          end else if (!bus_q.rd && !o_rd) begin
            bus_q.rd   <= 1'b1;
            bus_q.addr <= sp_q;
          end else if (o_rd) begin
            case (pull_q)
              3'd0:    cc_q     <= i_rdata | CC_FIXED_ONES;
              3'd1:    acc_q    <= i_rdata;
              3'd2:    idx_lo_q <= i_rdata;
              3'd3:    pc_q[15:8] <= i_rdata;
              default: pc_q[7:0]  <= i_rdata;
            endcase
            pull_q   <= 3'(pull_q + 3'd1);
            pull_n_q <= 3'(pull_n_q - 3'd1);
            if (pull_n_q != 3'd1) sp_q <= 16'(sp_q + 16'h0001);
          end
        end
        S_HALT: begin
          // second store byte of the pair, otherwise stop holds forever
          if (!halted_q) begin
            bus_q.wr    <= 1'b1;
            bus_q.addr  <= opnd_q;
            bus_q.wdata <= idx_lo_q;
            pre_q       <= 1'b0;
            state_q     <= S_FETCH;
          end
        end
        // an unreachable state recovers through a fresh fetch
        default: state_q <= S_FETCH;
      endcase
    end
  end
endmodule : csrd_core
`default_nettype wire

// File: csrd_core_asserts.sv
// bus and status checks on the decoder core ports
`timescale 1ns/1ns
`default_nettype none
module csrd_core_asserts (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic [7:0]  i_rdata,
  input wire logic        o_rd,
  input wire logic        o_wr,
  input wire logic [15:0] o_addr,
  input wire logic [7:0]  o_wdata,
  input wire logic        o_halted,
  input wire logic        o_illegal
);
  // one clock domain, checks paused while reset is held, all but the reset-quiet check
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_bus_excl: assert property (!(o_rd && o_wr))
    else $error("read and write strobes together");
  a_reset_quiet: assert property (disable iff (1'b0)
    i_srst |=> !(o_rd || o_wr || o_halted || o_illegal))
    else $error("activity while reset held");
  a_first_fetch: assert property ($fell(i_srst) |-> ##[1:3] (o_rd && o_addr == 16'h0000))
    else $error("first fetch not at address zero");
  a_halt_sticky: assert property (o_halted |=> o_halted)
    else $error("halt dropped without reset");
  a_halt_silent: assert property (o_halted |-> !o_rd && !o_wr)
    else $error("bus cycle while halted");
  a_illegal_nowr: assert property (o_illegal |-> !o_wr)
    else $error("write on skipped opcode");
  a_illegal_pulse: assert property (o_illegal |=> !o_illegal)
    else $error("skip flag longer than one cycle");
  a_addr_hold: assert property (!o_rd && !o_wr |-> $stable(o_addr))
    else $error("address moved between requests");
  a_wdata_hold: assert property (!o_wr |-> $stable(o_wdata))
    else $error("write data moved between writes");

  // main traffic kinds reached
  c_store: cover property (o_wr);
  c_halt: cover property ($rose(o_halted));
  c_skip: cover property (o_illegal);
endmodule : csrd_core_asserts
`default_nettype wire

// File: csrd_mem_model.sv
// behavioural memory on the far side of the decoder bus
`timescale 1ns/1ns
`default_nettype none
module csrd_mem_model
  import csrd_pkg::*;
(
  input  wire logic         i_clk,
  input  wire csrd_bus_type i_bus,
  output logic [7:0]        o_rdata
);
  logic [7:0] mem [0:65535];

  // cleared so unwritten code reads as an unused opcode
  initial begin
    for (int k = 0; k < 65536; k++) mem[k] = 8'h00;
  end

  // stores land at the edge that samples the write strobe
  always @(posedge i_clk) begin
    if (i_bus.wr) mem[i_bus.addr] <= i_bus.wdata;
  end

  // unselected reads show the inverse so stale data never passes
  assign o_rdata = i_bus.rd ? mem[i_bus.addr] : ~mem[i_bus.addr];
endmodule : csrd_mem_model
`default_nettype wire

// File: test_cpu_store_return_decode.sv
// self-checking bench for the store and return decoder core
`timescale 1ns/1ns
`default_nettype none
module test_cpu_store_return_decode;
  import csrd_pkg::*;
  logic         i_clk;
  logic         i_srst;
  logic [7:0]   rdata;
  csrd_bus_type bus;
  logic         halted;
  logic         illegal;
  int           ill_count;
  int           err_count;
  int           cmp_count;

  csrd_core dut (.i_clk(i_clk), .i_srst(i_srst), .i_rdata(rdata), .o_rd(bus.rd),
    .o_wr(bus.wr), .o_addr(bus.addr), .o_wdata(bus.wdata), .o_halted(halted),
    .o_illegal(illegal));
  csrd_mem_model u_mem (.i_clk(i_clk), .i_bus(bus), .o_rdata(rdata));

  // counts skipped-opcode pulses, one per refused byte
  always @(posedge i_clk) begin
    if (illegal === 1'b1) ill_count++;
  end

  // system clock, 40 ns period
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic load(input logic [15:0] a, input logic [7:0] d[$]);
    foreach (d[k]) u_mem.mem[a + 16'(k)] = d[k];
  endtask : load

  // four reset edges, then run until halt under a bounded count
  task automatic run_prog();
    int n;
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    #1;
    check({15'h0000, halted}, 16'h0000);
    n = 0;
    while (halted !== 1'b1) begin
      @(posedge i_clk);
      n++;
      if (n > 3000) begin
        err_count++;
        return;
      end
    end
  endtask : run_prog

  // interrupt return loads flags, a, x and pc; sta in direct, extended, indexed and 8-bit offset forms, stx and pair store direct and sp 8-bit; return keeps carry
  task automatic scen_return_store();
    load(16'h0000, '{8'h80});
    load(16'h0100, '{8'h01, 8'h50, 8'h34, 8'h03, 8'h00});
    load(16'h0200, '{8'h04, 8'h00, 8'hAA, 8'hAA, 8'hAA, 8'hAA});
    load(16'h0050, '{8'hAA, 8'hAA, 8'hAA});
    load(16'h0300, '{8'hA2, 8'h10, 8'hB7, 8'h40, 8'h99, 8'hA2, 8'h00, 8'hC7, 8'h12, 8'h34,
      8'h35, 8'h50, 8'hBF, 8'h52, 8'hF7, 8'hE7, 8'h02, 8'h9C, 8'h9E, 8'hEF, 8'h03,
      8'h9E, 8'hFF, 8'h05, 8'h99, 8'h81});
    load(16'h0400, '{8'hB2, 8'h40, 8'hB7, 8'h41, 8'hA2, 8'h00, 8'hB7, 8'h42, 8'h00, 8'h9B,
      8'h8E});
    run_prog();
    check({8'h00, u_mem.mem[16'h0040]}, 16'h003F);
    check({8'h00, u_mem.mem[16'h1234]}, 16'h003E);
    check({8'h00, u_mem.mem[16'h0050]}, 16'h0000);
    check({8'h00, u_mem.mem[16'h0051]}, 16'h0034);
    check({8'h00, u_mem.mem[16'h0052]}, 16'h0034);
    check({8'h00, u_mem.mem[16'h0034]}, 16'h003E);
    check({8'h00, u_mem.mem[16'h0036]}, 16'h003E);
    check({8'h00, u_mem.mem[16'h0202]}, 16'h0034);
    check({8'h00, u_mem.mem[16'h0204]}, 16'h0000);
    check({8'h00, u_mem.mem[16'h0205]}, 16'h0034);
    check({8'h00, u_mem.mem[16'h0041]}, 16'h00FE);
    check({8'h00, u_mem.mem[16'h0042]}, 16'h00FD);
    check(16'(ill_count), 16'h0001);
  endtask : scen_return_store

  // second reset must keep a and x, clear only the high index byte
  task automatic scen_rereset();
    load(16'h0000, '{8'h35, 8'h10, 8'hB7, 8'h12, 8'h8E});
    load(16'h0010, '{8'hAA, 8'hAA, 8'hAA});
    run_prog();
    check({8'h00, u_mem.mem[16'h0010]}, 16'h0000);
    check({8'h00, u_mem.mem[16'h0011]}, 16'h0034);
    check({8'h00, u_mem.mem[16'h0012]}, 16'h00FD);
    check(16'(ill_count), 16'h0001);
  endtask : scen_rereset

  // main sequence, loads wait one edge for the memory to clear
  initial begin
    i_srst = 1'b1;
    err_count = 0;
    cmp_count = 0;
    ill_count = 0;
    @(posedge i_clk);
    scen_return_store();
    scen_rereset();
    finish_test();
  end
endmodule : test_cpu_store_return_decode

bind csrd_core csrd_core_asserts u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_rdata(i_rdata),
  .o_rd(o_rd), .o_wr(o_wr), .o_addr(o_addr), .o_wdata(o_wdata), .o_halted(o_halted),
  .o_illegal(o_illegal));
`default_nettype wire
